// ==== hw/clk_div_unit.sv ====
// One output divider with sync hold, aligned restart and start delay.
// Assumes hold and restart come from the same synchronised sync level.
`timescale 1ns/10ps

module clk_div_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hold_i,
   input wire logic restart_i,
   input wire logic drive_low_i,
   input wire logic [clk_sync_pkg::DIV_W-1:0] ratio_m1_i,
   input wire logic [clk_sync_pkg::PH_W-1:0] phase_i,
   output logic clk_o
);
   import clk_sync_pkg::*;

   logic [DIV_W-1:0] cnt_ff;
   logic [PH_W-1:0] dly_ff;
   logic out_ff;

   // Toggle every ratio cycles: 50% duty for odd and even ratios alike
   wire logic wrap = (cnt_ff == ratio_m1_i);
   wire logic [DIV_W-1:0] cnt_inc = cnt_ff + 10'h001;
   wire logic [PH_W-1:0] dly_dec = dly_ff - 11'h001;

   // Divider state; hold wins over everything but reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
         dly_ff <= '0;
         out_ff <= 1'b0;
      end else if (hold_i) begin
         cnt_ff <= '0;
         dly_ff <= '0;
         if (drive_low_i) begin
            out_ff <= 1'b0;
         end
      end else if (restart_i) begin
         cnt_ff <= '0;
         dly_ff <= phase_i;
         out_ff <= (phase_i == 11'h000);
      end else if (dly_ff != 11'h000) begin
         dly_ff <= dly_dec;
         out_ff <= (dly_ff == 11'h001);
      end else if (wrap) begin
         cnt_ff <= '0;
         out_ff <= ~out_ff;
      end else begin
         cnt_ff <= cnt_inc;
      end
   end

   assign clk_o = out_ff;

endmodule : clk_div_unit

// ==== hw/clk_sync_pkg.sv ====
// Shared constants, types and strap decode tables for the output sync block.
// Assumes one 100 MHz clock; each clock cycle stands for half a reference period.

package clk_sync_pkg;

   // ***************************************************************
   // Sizes
   // ***************************************************************
   localparam int NUM_OUT = 4;
   localparam int STRAP_PINS = 6;
   localparam int LVL_W = 3;
   localparam int DIV_W = 10;
   localparam int PH_W = 11;
   localparam int LVLS_W = STRAP_PINS * LVL_W;

   // ***************************************************************
   // Register map, byte addresses on the bus
   // ***************************************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] LEVEL_OFS = 8'h08;
   localparam logic [7:0] OUTCFG_OFS = 8'h10;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h0000_000F;
   localparam logic [31:0] OUTCFG_RST = 32'h0000_0400;
   localparam logic [31:0] OUTCFG_MASK = 32'h07FF_0FFF;
   localparam int RATIO_LSB = 0;
   localparam int KIND_LSB = 10;
   localparam int PHASE_LSB = 16;
   localparam int ST_STRAP_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_VALID_BIT = 2;
   localparam int ST_SYNC_BIT = 3;
   localparam int ST_KIND_LSB = 4;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCAN_STEP_NS = 100;
   localparam int SCAN_STEP_CYC = (SCAN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      KIND_HIZ = 2'b00,
      KIND_LVDS = 2'b01,
      KIND_HSTL = 2'b10,
      KIND_TOGGLE = 2'b11
   } kind_type;

   typedef struct packed {
      logic [DIV_W-1:0] ratio_m1;
      kind_type kind;
      logic [PH_W-1:0] phase;
   } out_cfg_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_type;

   // ***************************************************************
   // Strap decode tables
   // ***************************************************************
   // Level to divide ratio minus one: 1,2,3,4,5,6,8,16
   function automatic logic [DIV_W-1:0] div_of_level(input logic [LVL_W-1:0] lvl);
      logic [DIV_W-1:0] r;
      r = 10'h000;
      case (lvl)
         3'h6: r = 10'h007;
         3'h7: r = 10'h00F;
         default: r = {7'h00, lvl};
      endcase
      return r;
   endfunction : div_of_level

   // First output of a pair
   function automatic kind_type kind_first(input logic [LVL_W-1:0] lvl);
      kind_type k;
      k = KIND_HIZ;
      case (lvl)
         3'h0, 3'h3, 3'h6: k = KIND_HSTL;
         3'h1, 3'h4: k = KIND_LVDS;
         default: k = KIND_HIZ;
      endcase
      return k;
   endfunction : kind_first

   // Second output of a pair
   function automatic kind_type kind_second(input logic [LVL_W-1:0] lvl);
      kind_type k;
      k = KIND_HIZ;
      case (lvl)
         3'h0, 3'h1, 3'h2: k = KIND_HSTL;
         3'h3, 3'h4, 3'h5: k = KIND_LVDS;
         default: k = KIND_HIZ;
      endcase
      return k;
   endfunction : kind_second

endpackage : clk_sync_pkg

// ==== hw/output_sync_and_strap_config.sv ====
// Output sync control, four dividers, strap decode and Wishbone registers.
// Assumes pins are asynchronous to clk_i and a classic Wishbone master.
//
// Summary of operation
// - Serial mode dividers reset to divide by one
// - Sync low holds affected outputs static
// - Released outputs restart with edges aligned
// - Masked outputs keep toggling during sync
// - Unmasked toggle-mode outputs driven low in sync
// - Strap mode takes settings from six pins
// - Strap mode: ratio max 16, no phase
// - Strap settings apply after full six-pin scan
// - Scan at reset and every sync toggle
// - Levels 0-7 give ratios 1..6,8,16
// - Pins four and five set pair output types
// - Grounded strap decodes level zero, HSTL, div1
// - Phase and sync applied on sync rise
// - Ten-bit divider, 50% duty any ratio
`timescale 1ns/10ps

module output_sync_and_strap_config #(
   parameter int SCAN_STEP = clk_sync_pkg::SCAN_STEP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire clk_sync_pkg::wb_req_type wb_req_i,
   output clk_sync_pkg::wb_rsp_type wb_rsp_o,
   input wire logic sync_n_i,
   input wire logic strap_mode_select_i,
   input wire logic [2:0] strap_pin_zero_i,
   input wire logic [2:0] strap_pin_one_i,
   input wire logic [2:0] strap_pin_two_i,
   input wire logic [2:0] strap_pin_three_i,
   input wire logic [2:0] strap_pin_four_i,
   input wire logic [2:0] strap_pin_five_i,
   output logic clock_output_zero_o,
   output logic clock_output_one_o,
   output logic clock_output_two_o,
   output logic clock_output_three_o,
   output logic [3:0] out_enable_o,
   output logic [7:0] out_kind_o
);
   import clk_sync_pkg::*;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [LVLS_W+1:0] pin_meta_ff;
   logic [LVLS_W+1:0] pin_sync_ff;
   logic sync_prev_ff;

   wire logic [LVLS_W+1:0] pin_raw = {sync_n_i, strap_mode_select_i, strap_pin_five_i,
      strap_pin_four_i, strap_pin_three_i, strap_pin_two_i, strap_pin_one_i,
      strap_pin_zero_i};

   // Two stages; only the second stage is read by logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_ff <= {1'b1, {(LVLS_W + 1){1'b0}}};
         pin_sync_ff <= {1'b1, {(LVLS_W + 1){1'b0}}};
         sync_prev_ff <= 1'b1;
      end else begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
         sync_prev_ff <= pin_sync_ff[LVLS_W+1];
      end
   end

   wire logic sync_hi = pin_sync_ff[LVLS_W+1];
   wire logic sync_low = ~sync_hi;
   wire logic sync_rise = sync_hi & ~sync_prev_ff;
   wire logic strap_on = pin_sync_ff[LVLS_W];
   wire logic [LVLS_W-1:0] pin_lvl = pin_sync_ff[LVLS_W-1:0];

   // ***************************************************************
   // Strap scanner
   // ***************************************************************
   logic [LVLS_W-1:0] strap_lvl;
   logic scan_busy;
   logic scan_valid;

   // A release after a low period is the toggle that starts a rescan
   strap_scan #(
      .STEP_CYC(SCAN_STEP)
   ) u_scan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(sync_rise),
      .pin_lvl_i(pin_lvl),
      .lvl_o(strap_lvl),
      .busy_o(scan_busy),
      .valid_o(scan_valid)
   );

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [31:0] ctrl_ff;
   logic [31:0] outcfg_ff [NUM_OUT];
   logic ack_ff;
   logic [31:0] rdat_ff;

   // Byte-lane merge for a masked register word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel,
                                              input logic [31:0] mask);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & mask;
      return (old_v & ~m) | (new_v & m);
   endfunction : lane_merge

   wire logic req = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
   wire logic wr = req & wb_req_i.we;
   wire logic hit_ctrl = (wb_req_i.adr == CTRL_OFS);
   wire logic hit_status = (wb_req_i.adr == STATUS_OFS);
   wire logic hit_level = (wb_req_i.adr == LEVEL_OFS);
   wire logic hit_cfg = (wb_req_i.adr[7:4] == OUTCFG_OFS[7:4]) && (wb_req_i.adr[1:0] == 2'b00);
   wire logic [1:0] cfg_idx = wb_req_i.adr[3:2];

   // Serial-mode view of each output and the effective selection
   out_cfg_type ser_cfg [NUM_OUT];
   out_cfg_type eff_cfg [NUM_OUT];
   logic [3:0] mask;
   logic [7:0] kinds;
   assign mask = ctrl_ff[3:0];

   for (genvar i = 0; i < NUM_OUT; i++) begin : g_cfg
      wire logic [LVL_W-1:0] div_lvl = strap_lvl[i*LVL_W +: LVL_W];
      wire logic [LVL_W-1:0] kind_lvl = strap_lvl[(4 + i/2)*LVL_W +: LVL_W];
      wire kind_type strap_kind = (i % 2 == 0) ? kind_first(kind_lvl) : kind_second(kind_lvl);
      assign ser_cfg[i].ratio_m1 = outcfg_ff[i][RATIO_LSB +: DIV_W];
      assign ser_cfg[i].kind = kind_type'(outcfg_ff[i][KIND_LSB +: 2]);
      assign ser_cfg[i].phase = outcfg_ff[i][PHASE_LSB +: PH_W];
      // Strap: table ratio, table type, no phase; nothing drives before a scan
      assign eff_cfg[i].ratio_m1 = strap_on ? div_of_level(div_lvl)
                                            : ser_cfg[i].ratio_m1;
      assign eff_cfg[i].kind = !strap_on ? ser_cfg[i].kind
                             : (scan_valid ? strap_kind : KIND_HIZ);
      assign eff_cfg[i].phase = strap_on ? '0 : ser_cfg[i].phase;
      assign kinds[2*i +: 2] = eff_cfg[i].kind;
   end

   wire logic [31:0] status_word = {20'h00000, kinds, sync_low, scan_valid, scan_busy, strap_on};

   // Read selection; unmapped addresses read zero and still acknowledge
   wire logic [31:0] rd_mux = hit_ctrl ? ctrl_ff
                            : hit_status ? status_word
                            : hit_level ? {14'h0000, strap_lvl}
                            : hit_cfg ? outcfg_ff[cfg_idx]
                            : 32'h0000_0000;

   // Control and output config writes; dividers default to divide by one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RST;
         for (int i = 0; i < NUM_OUT; i++) begin
            outcfg_ff[i] <= OUTCFG_RST;
         end
      end else if (wr && hit_ctrl) begin
         ctrl_ff <= lane_merge(ctrl_ff, wb_req_i.dat, wb_req_i.sel, CTRL_MASK);
      end else if (wr && hit_cfg) begin
         outcfg_ff[cfg_idx] <= lane_merge(outcfg_ff[cfg_idx], wb_req_i.dat,
                                          wb_req_i.sel, OUTCFG_MASK);
      end
   end

   // One-cycle answer, dropped the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= req;
         rdat_ff <= req ? rd_mux : 32'h0000_0000;
      end
   end

   assign wb_rsp_o.ack = ack_ff;
   assign wb_rsp_o.dat = rdat_ff;

   // ***************************************************************
   // Dividers
   // ***************************************************************
   logic [3:0] clk_out;

   // All unmasked units see the same released cycle, so edges line up
   for (genvar i = 0; i < NUM_OUT; i++) begin : g_div
      clk_div_unit u_div (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .hold_i(sync_low & ~mask[i]),
         .restart_i(sync_rise & ~mask[i]),
         .drive_low_i(eff_cfg[i].kind == KIND_TOGGLE),
         .ratio_m1_i(eff_cfg[i].ratio_m1),
         .phase_i(eff_cfg[i].phase),
         .clk_o(clk_out[i])
      );
      assign out_enable_o[i] = (eff_cfg[i].kind != KIND_HIZ);
   end

   assign clock_output_zero_o = clk_out[0];
   assign clock_output_one_o = clk_out[1];
   assign clock_output_two_o = clk_out[2];
   assign clock_output_three_o = clk_out[3];
   assign out_kind_o = kinds;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   div1_reset_a: assert property ($past(rst_i) |-> outcfg_ff[0][9:0] == 10'h000)
      else $error("divider not divide-by-one after reset");
   hold_static_a: assert property ((sync_low & ~mask[0]) [*2] |=> $stable(clk_out[0]))
      else $error("held output moved");
   edge_align_a: assert property ((sync_rise && !mask[0] && !mask[3]
      && eff_cfg[0].phase == 11'h000 && eff_cfg[3].phase == 11'h000)
      |=> (clk_out[0] && clk_out[3]))
      else $error("outputs not aligned on release");
   mask_run_a: assert property ((mask[1] && eff_cfg[1].ratio_m1 == 10'h000
      && $stable(eff_cfg[1].ratio_m1) && $past(mask[1]) && $changed(clk_out[1]))
      |=> $changed(clk_out[1]))
      else $error("masked output stopped");
   pull_low_a: assert property ((sync_low && !mask[0] && eff_cfg[0].kind == KIND_TOGGLE)
      |=> !clk_out[0])
      else $error("toggle-mode output not low in sync");
   strap_type_a: assert property ((strap_on && scan_valid)
      |-> kinds[1:0] == kind_first(strap_lvl[14:12])
       && kinds[7:6] == kind_second(strap_lvl[17:15]))
      else $error("strap output type mismatch");
   strap_limit_a: assert property (strap_on |-> eff_cfg[3].phase == 11'h000
      && eff_cfg[3].ratio_m1 <= 10'h00F && eff_cfg[3].kind != KIND_TOGGLE)
      else $error("strap limits broken");
   scan_commit_a: assert property ($changed(strap_lvl) |-> $fell(scan_busy))
      else $error("strap levels changed outside scan end");
   scan_start_a: assert property (sync_rise |-> ##[1:2] scan_busy)
      else $error("sync toggle did not start a scan");
   div_table_a: assert property ((strap_on && strap_lvl[8:6] == 3'h7)
      |-> eff_cfg[2].ratio_m1 == 10'h00F)
      else $error("level seven not divide-by-16");
   ground_zero_a: assert property ((strap_on && scan_valid && strap_lvl[2:0] == 3'h0
      && strap_lvl[14:12] == 3'h0) |-> eff_cfg[0].ratio_m1 == 10'h000
      && eff_cfg[0].kind == KIND_HSTL)
      else $error("grounded strap misdecoded");
   restart_same_a: assert property ((sync_rise && !mask[2]
      && eff_cfg[2].phase != 11'h000) |=> !clk_out[2])
      else $error("delayed output started early");

   sync_pulse_c: cover property (sync_low ##[1:20] sync_rise);
   scan_done_c: cover property ($fell(scan_busy) && strap_on);
   masked_run_c: cover property (sync_low && mask[1] && $changed(clk_out[1]));

endmodule : output_sync_and_strap_config

// ==== hw/strap_scan.sv ====
// Sequential scan of the six strap levels with commit after the last pin.
// Assumes the levels are already synchronised to clk_i.
`timescale 1ns/10ps

module strap_scan #(
   parameter int STEP_CYC = clk_sync_pkg::SCAN_STEP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [clk_sync_pkg::LVLS_W-1:0] pin_lvl_i,
   output logic [clk_sync_pkg::LVLS_W-1:0] lvl_o,
   output logic busy_o,
   output logic valid_o
);
   import clk_sync_pkg::*;

   typedef enum logic [0:0] {
      SCAN_IDLE = 1'b0,
      SCAN_RUN = 1'b1
   } scan_state_type;

   scan_state_type state_ff;
   logic pend_ff;
   logic [15:0] step_ff;
   logic [2:0] pin_ff;
   logic [LVLS_W-1:0] shadow_ff;
   logic [LVLS_W-1:0] lvl_ff;
   logic valid_ff;

   wire logic step_end = (step_ff == 16'(STEP_CYC - 1));
   wire logic last_pin = (pin_ff == 3'(STRAP_PINS - 1));
   wire logic [LVL_W-1:0] cur_lvl = pin_lvl_i[pin_ff*LVL_W +: LVL_W];

   // Pending start survives a request that lands mid-scan; reset requests one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_ff <= 1'b1;
      end else if (start_i && state_ff == SCAN_RUN) begin
         pend_ff <= 1'b1;
      end else if (state_ff == SCAN_IDLE) begin
         pend_ff <= 1'b0;
      end
   end

   // Scan walker; strap changes between scans are never seen here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= SCAN_IDLE;
         step_ff <= '0;
         pin_ff <= '0;
         shadow_ff <= '0;
         lvl_ff <= '0;
         valid_ff <= 1'b0;
      end else begin
         case (state_ff)
            SCAN_IDLE: begin
               if (pend_ff || start_i) begin
                  state_ff <= SCAN_RUN;
                  step_ff <= '0;
                  pin_ff <= '0;
               end
            end
            SCAN_RUN: begin
               if (step_end) begin
                  step_ff <= '0;
                  shadow_ff[pin_ff*LVL_W +: LVL_W] <= cur_lvl;
                  if (last_pin) begin
                     lvl_ff <= {cur_lvl, shadow_ff[LVLS_W-LVL_W-1:0]};
                     valid_ff <= 1'b1;
                     state_ff <= SCAN_IDLE;
                  end else begin
                     pin_ff <= pin_ff + 3'h1;
                  end
               end else begin
                  step_ff <= step_ff + 16'h0001;
               end
            end
            default: state_ff <= SCAN_IDLE;
         endcase
      end
   end

   assign lvl_o = lvl_ff;
   assign busy_o = (state_ff == SCAN_RUN);
   assign valid_o = valid_ff;

endmodule : strap_scan

// ==== verification/strap_board_model.sv ====
// Board model: strap converter levels, strap mode level and the host sync pin.
// Assumes the bench calls its tasks from one process clocked by clk_i.
`timescale 1ns/10ps

module strap_board_model (
   input wire logic clk_i,
   output logic sync_n_o,
   output logic mode_o,
   output logic [17:0] lvls_o
);
   // ***************************************************************
   // Pins
   // ***************************************************************
   // Straps are resistors, so levels stay put between changes
   initial begin
      sync_n_o = 1'h1;
      mode_o = 1'h0;
      lvls_o = 18'h358D1;
   end

   // New strap values, launched just after an edge
   task automatic set_straps(input logic mode, input logic [17:0] lvls);
      @(posedge clk_i);
      mode_o <= mode;
      lvls_o <= lvls;
   endtask : set_straps

   // Host sync level; a release after a low makes straps count
   task automatic drive_sync(input logic lvl);
      @(posedge clk_i);
      sync_n_o <= lvl;
   endtask : drive_sync
endmodule : strap_board_model

// ==== verification/test_output_sync_and_strap_config.sv ====
// Self-checking bench for the output sync and strap configuration block.
// Assumes the board model drives sync and straps; scan step shortened to 2.
`timescale 1ns/10ps

`define CHK(what, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("BAD %s expected %0h seen %0h", what, exp, got); \
      end \
   end

module test_output_sync_and_strap_config;
   import clk_sync_pkg::*;
   // ***************************************************************
   // Signals and instances
   // ***************************************************************
   logic clk_i;
   logic rst_i;
   wb_req_type req;
   wb_rsp_type rsp;
   logic sync_n, mode;
   logic [17:0] lvls;
   logic [3:0] outs, out_en;
   logic [7:0] out_kind;
   logic [31:0] rd;
   int n_mismatch = 0;
   int n_checks = 0;
   int div_tab[8] = '{1, 2, 3, 4, 5, 6, 8, 16};
   kind_type k1_tab[8] = '{KIND_HSTL, KIND_LVDS, KIND_HIZ, KIND_HSTL, KIND_LVDS, KIND_HIZ,
      KIND_HSTL, KIND_HIZ};
   kind_type k2_tab[8] = '{KIND_HSTL, KIND_HSTL, KIND_HSTL, KIND_LVDS, KIND_LVDS, KIND_LVDS,
      KIND_HIZ, KIND_HIZ};

   strap_board_model strap_board_model_i (.clk_i(clk_i), .sync_n_o(sync_n), .mode_o(mode),
      .lvls_o(lvls));

   // Short scan step keeps each rescan to a dozen cycles
   output_sync_and_strap_config #(.SCAN_STEP(2)) output_sync_and_strap_config_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .sync_n_i(sync_n),
      .strap_mode_select_i(mode), .strap_pin_zero_i(lvls[2:0]), .strap_pin_one_i(lvls[5:3]),
      .strap_pin_two_i(lvls[8:6]), .strap_pin_three_i(lvls[11:9]),
      .strap_pin_four_i(lvls[14:12]), .strap_pin_five_i(lvls[17:15]),
      .clock_output_zero_o(outs[0]), .clock_output_one_o(outs[1]),
      .clock_output_two_o(outs[2]), .clock_output_three_o(outs[3]),
      .out_enable_o(out_en), .out_kind_o(out_kind));

   initial begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end

   // ***************************************************************
   // Bus and measuring tasks
   // ***************************************************************
   // Classic cycle held until ack is sampled, data taken at that edge
   task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
         output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: wdat};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'h1 && n < 20);
      rdat = rsp.dat;
      req <= '0;
      `CHK("ack", 1'h1, rsp.ack)
   endtask : wb_io

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wb_io(1'h1, adr, dat, d);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      wb_io(1'h0, adr, 32'h0, rd);
      `CHK(what, exp, rd)
   endtask : rd_chk

   // Period and high time between two rises, sampled mid-cycle
   task automatic measure(input int idx, output int per, output int hi);
      int n, seen;
      logic prev;
      per = 0;
      hi = 0;
      seen = 0;
      n = 0;
      prev = outs[idx];
      while (seen < 2 && n < 9000) begin
         @(negedge clk_i);
         n++;
         if (outs[idx] === 1'h1 && prev === 1'h0) seen++;
         if (seen == 1) begin
            per++;
            hi += int'(outs[idx] === 1'h1);
         end
         prev = outs[idx];
      end
   endtask : measure

   // Low then high so the device rescans the straps
   task automatic pulse_sync();
      strap_board_model_i.drive_sync(1'h0);
      repeat (4) @(posedge clk_i);
      strap_board_model_i.drive_sync(1'h1);
   endtask : pulse_sync

   task automatic wait_scan();
      int n;
      n = 0;
      repeat (6) @(posedge clk_i);
      do begin
         wb_io(1'h0, STATUS_OFS, 32'h0, rd);
         n++;
      end while (rd[ST_BUSY_BIT] !== 1'h0 && n < 40);
      `CHK("scan valid", 1'h1, rd[ST_VALID_BIT])
   endtask : wait_scan

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_reset_values();
      int p, h;
      rd_chk("ctrl", CTRL_OFS, CTRL_RST);
      for (int i = 0; i < 4; i++) rd_chk("outcfg", OUTCFG_OFS + 8'(4 * i), 32'h400);
      rd_chk("unmapped", 8'h0C, 32'h0);
      rd_chk("reset scan", LEVEL_OFS, 32'h358D1);
      measure(0, p, h);
      `CHK("div1 period", 2, p)
   endtask : t_reset_values

   task automatic t_sync_hold();
      int p, h, n;
      logic [3:0] s, saw;
      wr(CTRL_OFS, 32'hFFFF_FFF2);
      rd_chk("mask", CTRL_OFS, 32'h2);
      wr(OUTCFG_OFS, 32'h0000_0C02);
      wr(OUTCFG_OFS + 8'h4, 32'h0000_0400);
      wr(OUTCFG_OFS + 8'h8, 32'h0002_0800);
      wr(OUTCFG_OFS + 8'hC, 32'h0000_07FF);
      measure(3, p, h);
      `CHK("div1024 period", 2048, p)
      `CHK("div1024 high", 1024, h)
      measure(0, p, h);
      `CHK("div3 period", 6, p)
      `CHK("div3 high", 3, h)
      strap_board_model_i.drive_sync(1'h0);
      repeat (6) @(negedge clk_i);
      s = outs;
      saw = 4'h0;
      `CHK("toggle kind low", 1'h0, outs[0])
      repeat (8) begin
         @(negedge clk_i);
         saw |= outs ^ s;
      end
      `CHK("held static", 3'h0, {saw[3], saw[2], saw[0]})
      `CHK("masked runs", 1'h1, saw[1])
      strap_board_model_i.drive_sync(1'h1);
      n = 0;
      while (outs[0] !== 1'h1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      `CHK("aligned start", 2'h2, {outs[3], outs[2]})
      @(negedge clk_i);
      `CHK("phase wait", 1'h0, outs[2])
      @(negedge clk_i);
      `CHK("phase rise", 1'h1, outs[2])
   endtask : t_sync_hold

   task automatic t_strap();
      int p, h;
      logic [31:0] lv;
      for (int l = 0; l < 8; l++) begin
         lv = (32'(l) << 6) | (32'(l) << 12);
         strap_board_model_i.set_straps(1'h1, lv[17:0]);
         pulse_sync();
         wait_scan();
         `CHK("strap mode", 1'h1, rd[ST_STRAP_BIT])
         rd_chk("levels", LEVEL_OFS, lv);
         `CHK("kind0", k1_tab[l], out_kind[1:0])
         `CHK("kind1", k2_tab[l], out_kind[3:2])
         `CHK("kind2", KIND_HSTL, out_kind[5:4])
         `CHK("enable0", k1_tab[l] != KIND_HIZ, out_en[0])
         measure(2, p, h);
         `CHK("strap period", 2 * div_tab[l], p)
      end
      strap_board_model_i.set_straps(1'h1, 18'h001C0);
      repeat (20) @(posedge clk_i);
      rd_chk("ignored", LEVEL_OFS, 32'h71C0);
   endtask : t_strap

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      rst_i = 1'h1;
      req = '0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (20) @(posedge clk_i);
      t_reset_values();
      t_sync_hold();
      t_strap();
      report_and_stop();
   end

   // Whole run is near 3.6k cycles; this cuts a hang
   initial begin
      #400000;
      n_mismatch++;
      report_and_stop();
   end
endmodule : test_output_sync_and_strap_config
